//--- udisc_ctrl.sv
// USB device control, suspend/resume, remote wake-up and interrupt logic
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "udisc_consts.svh"

module udisc_ctrl
  import udisc_pkg::*;
#(
  parameter int SUSPEND_CYCLES = (`UDISC_SUSPEND_US * `UDISC_CLK_MHZ),
  parameter int WAKE_K_CYCLES = (`UDISC_WAKE_K_US * `UDISC_CLK_MHZ),
  parameter int NUM_EP = 8,
  parameter int CNT_W = 20
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Bus-side events from the serial engine and line state
  input wire logic i_bus_idle,
  input wire logic i_bus_reset,
  input wire logic i_sof_pid,
  input wire logic i_bus_resume,
  input wire logic i_remote_wake_enable,
  input wire logic [NUM_EP-1:0] i_ep_cause,
  input wire logic [NUM_EP-1:0] i_ep_ready,
  input wire logic [NUM_EP-1:0] i_ep_bank_release,
  // Outputs toward transceiver, clocking and CPU
  output logic o_drive_k,
  output logic o_pullup_connect,
  output logic o_module_run,
  output logic o_osc_off,
  output logic o_wakeup,
  output logic o_irq_endpoint,
  output logic o_irq_protocol,
  output logic [15:0] o_irq_vector,
  output logic [NUM_EP-1:0] o_ep_nak,
  output logic [NUM_EP-1:0] o_ep_bank
);

  // Pin-side inputs pass two flops before any logic reads them
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [NUM_EP-1:0] ep_sync_a;
  logic [NUM_EP-1:0] ep_sync_b;
  logic [NUM_EP-1:0] rdy_sync_a;
  logic [NUM_EP-1:0] rdy_sync_b;
  logic [NUM_EP-1:0] rel_sync_a;
  logic [NUM_EP-1:0] rel_sync_b;
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      ep_sync_a <= '0;
      ep_sync_b <= '0;
      rdy_sync_a <= '0;
      rdy_sync_b <= '0;
      rel_sync_a <= '0;
      rel_sync_b <= '0;
    end
    else
    begin
      sync_a <= {i_remote_wake_enable, i_bus_resume, i_sof_pid, i_bus_reset, i_bus_idle};
      sync_b <= sync_a;
      ep_sync_a <= i_ep_cause;
      ep_sync_b <= ep_sync_a;
      rdy_sync_a <= i_ep_ready;
      rdy_sync_b <= rdy_sync_a;
      rel_sync_a <= i_ep_bank_release;
      rel_sync_b <= rel_sync_a;
    end
  end
  logic idle_s;
  logic reset_s;
  logic sof_s;
  logic resume_s;
  logic wake_en_s;
  assign idle_s = sync_b[0];
  assign reset_s = sync_b[1];
  assign sof_s = sync_b[2];
  assign resume_s = sync_b[3];
  assign wake_en_s = sync_b[4];

  // Register and state storage
  logic [7:0] ctrl;
  logic [7:0] pflags;
  logic [7:0] pmask;
  logic [7:0] emask;
  logic [1:0] sys;
  logic reset_d;
  logic suspended;
  logic [CNT_W-1:0] idle_cnt;
  logic [CNT_W-1:0] k_cnt;
  udisc_wake_t wk_state;
  logic [NUM_EP-1:0] bank;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] next_ctrl;
  logic [7:0] next_pflags;
  logic [7:0] next_pmask;
  logic [7:0] next_emask;
  logic [1:0] next_sys;
  logic next_suspended;
  logic [CNT_W-1:0] next_idle_cnt;
  logic [CNT_W-1:0] next_k_cnt;
  udisc_wake_t next_wk_state;
  logic [NUM_EP-1:0] next_bank;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // APB decode: one word per register, byte address is four times the index
  logic acc;
  logic wr;
  logic [9:0] idx;
  logic mapped;
  assign acc = i_psel && i_penable && pready;
  assign wr = acc && i_pwrite;
  assign idx = i_paddr[11:2];
  assign mapped = (i_paddr[1:0] == 2'h0) && ((idx == 10'(`UDISC_IDX_CTRL))
    || (idx == 10'(`UDISC_IDX_PFLAGS)) || (idx == 10'(`UDISC_IDX_PMASK))
    || (idx == 10'(`UDISC_IDX_ESUM)) || (idx == 10'(`UDISC_IDX_EMASK))
    || (idx == 10'(`UDISC_IDX_GSTAT)) || (idx == 10'(`UDISC_IDX_SYS))
    || (idx == 10'(`UDISC_IDX_EPSTAT)));

  // Module runs only when enabled and not power-reduced
  logic run;
  assign run = ctrl[`UDISC_CR_ENABLE] && !sys[`UDISC_SYS_PWR_REDUCE];

  logic signalling;
  assign signalling = (wk_state == UDISC_WK_DRIVE);
  logic [7:0] gstat;
  assign gstat = {6'h00, signalling, wake_en_s};
  logic [7:0] esum;
  assign esum = ep_sync_b & {NUM_EP{run}};

  // Register, flag and suspend next-state logic
  always_comb
  begin
    next_ctrl = ctrl;
    next_pflags = pflags;
    next_pmask = pmask;
    next_emask = emask;
    next_sys = sys;
    next_suspended = suspended;
    next_idle_cnt = '0;
    next_prdata = 32'h0000_0000;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    // One wait state: ready answers in the second access cycle
    if (i_psel && i_penable && !pready)
    begin
      next_pready = 1'b1;
      next_pslverr = !mapped;
      if (!i_pwrite && mapped)
      begin
        case (idx)
          10'(`UDISC_IDX_CTRL): next_prdata = {24'h0, ctrl};
          10'(`UDISC_IDX_PFLAGS): next_prdata = {24'h0, pflags};
          10'(`UDISC_IDX_PMASK): next_prdata = {24'h0, pmask};
          10'(`UDISC_IDX_ESUM): next_prdata = {24'h0, esum};
          10'(`UDISC_IDX_EMASK): next_prdata = {24'h0, emask};
          10'(`UDISC_IDX_GSTAT): next_prdata = {24'h0, gstat};
          10'(`UDISC_IDX_SYS): next_prdata = {30'h0, sys};
          10'(`UDISC_IDX_EPSTAT): next_prdata = {16'h0, bank, o_ep_nak};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    // Software writes; flag writes store zero or one, so firmware may force events
    if (wr && mapped)
    begin
      case (idx)
        10'(`UDISC_IDX_CTRL): next_ctrl = i_pwdata[7:0] & `UDISC_CR_WMASK;
        10'(`UDISC_IDX_PFLAGS): next_pflags = i_pwdata[7:0] & `UDISC_PF_WMASK;
        10'(`UDISC_IDX_PMASK): next_pmask = i_pwdata[7:0] & `UDISC_PM_WMASK;
        10'(`UDISC_IDX_EMASK): next_emask = i_pwdata[7:0];
        10'(`UDISC_IDX_SYS): next_sys = i_pwdata[1:0];
        default: next_ctrl = ctrl;
      endcase
    end
    // Idle counter: 3 ms of bus idle is a suspend request
    if (run && idle_s && !suspended)
    begin
      next_idle_cnt = idle_cnt + CNT_W'(1);
      if (idle_cnt >= CNT_W'(SUSPEND_CYCLES - 1))
      begin
        next_suspended = 1'b1;
        next_idle_cnt = '0;
      end
    end
    if (suspended && (resume_s || reset_s || !run))
    begin
      next_suspended = 1'b0;
    end
    // Hardware sets win over a same-cycle software clear
    if (run)
    begin
      if (next_suspended && !suspended) next_pflags[`UDISC_PF_SUSPEND] = 1'b1;
      if (suspended && resume_s) next_pflags[`UDISC_PF_RESUME] = 1'b1;
      if (sof_s) next_pflags[`UDISC_PF_SOF] = 1'b1;
      if (reset_d && !reset_s) next_pflags[`UDISC_PF_RESET_END] = 1'b1;
      if (wk_state == UDISC_WK_IDLE && next_wk_state == UDISC_WK_DRIVE)
        next_pflags[`UDISC_PF_WAKE] = 1'b1;
    end
    else
    begin
      // Disabled module is held in reset
      next_pflags = 8'h00;
      next_suspended = 1'b0;
    end
  end

  // Remote wake-up sequence
  always_comb
  begin
    next_wk_state = wk_state;
    next_k_cnt = k_cnt;
    case (wk_state)
      UDISC_WK_IDLE:
      begin
        next_k_cnt = '0;
        if (run && suspended && wake_en_s && ctrl[`UDISC_CR_WAKE_REQ])
        begin
          next_wk_state = UDISC_WK_DRIVE;
        end
      end
      UDISC_WK_DRIVE:
      begin
        // Fixed K length; dropping the wake request does not cut it short, only loss of run does
        if (!run)
        begin
          next_wk_state = UDISC_WK_IDLE;
        end
        else if (k_cnt >= CNT_W'(WAKE_K_CYCLES - 1))
        begin
          next_wk_state = UDISC_WK_DONE;
        end
        else
        begin
          next_k_cnt = k_cnt + CNT_W'(1);
        end
      end
      UDISC_WK_DONE:
      begin
        // Wait for firmware to drop the request before another sequence
        if (!ctrl[`UDISC_CR_WAKE_REQ] || !run)
        begin
          next_wk_state = UDISC_WK_IDLE;
        end
      end
      default: next_wk_state = UDISC_WK_IDLE;
    endcase
  end

  // Double-banked endpoints swap bank on each release; others stay on bank zero
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_bank
      if (g >= 1 && g <= 3)
      begin : g_dbl
        assign next_bank[g] = run ? (bank[g] ^ rel_sync_b[g]) : 1'b0;
      end
      else
      begin : g_sgl
        assign next_bank[g] = 1'b0;
      end
    end
  endgenerate

  // State registers
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl <= 8'h00;
      pflags <= 8'h00;
      pmask <= `UDISC_PM_RESET;
      emask <= 8'h00;
      sys <= 2'h0;
      reset_d <= 1'b0;
      suspended <= 1'b0;
      idle_cnt <= '0;
      k_cnt <= '0;
      wk_state <= UDISC_WK_IDLE;
      bank <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      pflags <= next_pflags;
      pmask <= next_pmask;
      emask <= next_emask;
      sys <= next_sys;
      reset_d <= reset_s;
      suspended <= next_suspended;
      idle_cnt <= next_idle_cnt;
      k_cnt <= next_k_cnt;
      wk_state <= next_wk_state;
      bank <= next_bank;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Interrupt requests, computed from next values so outputs stay registered
  logic next_irq_p;
  logic next_irq_e;
  assign next_irq_p = next_sys[`UDISC_SYS_GIE] && (next_pflags[`UDISC_PF_RESET_END]
    || |(next_pflags[3:0] & next_pmask[3:0]));
  assign next_irq_e = next_sys[`UDISC_SYS_GIE] && run
    && |(ep_sync_b & next_emask);

  // Registered outputs
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_irq_protocol <= 1'b0;
      o_irq_endpoint <= 1'b0;
      o_irq_vector <= 16'h0000;
      o_drive_k <= 1'b0;
      o_pullup_connect <= 1'b0;
      o_module_run <= 1'b0;
      o_osc_off <= 1'b0;
      o_wakeup <= 1'b0;
      o_ep_nak <= '0;
      o_ep_bank <= '0;
    end
    else
    begin
      o_irq_protocol <= next_irq_p;
      o_irq_endpoint <= next_irq_e;
      // Endpoint vector has priority when both are pending
      o_irq_vector <= next_irq_e ? `UDISC_VEC_ENDPOINT
        : (next_irq_p ? `UDISC_VEC_PROTOCOL : 16'h0000);
      o_drive_k <= (next_wk_state == UDISC_WK_DRIVE);
      o_pullup_connect <= next_ctrl[`UDISC_CR_PULLUP];
      o_module_run <= next_ctrl[`UDISC_CR_ENABLE] && !next_sys[`UDISC_SYS_PWR_REDUCE];
      // Oscillator stays off past resume; the woken firmware's flag write restarts it
      o_osc_off <= next_suspended || (o_osc_off && run
        && !(wr && mapped && (idx == 10'(`UDISC_IDX_PFLAGS))));
      o_wakeup <= suspended && resume_s && run;
      o_ep_nak <= ~rdy_sync_b & {NUM_EP{run}};
      o_ep_bank <= next_bank;
    end
  end

  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = pslverr;

endmodule // udisc_ctrl

//--- udisc_consts.svh
// Register offsets, field positions, reset values and timing figures
`ifndef UDISC_CONSTS_SVH
`define UDISC_CONSTS_SVH
// Printed offsets are not multiples of four: these are indices
`define UDISC_IDX_CTRL 8'hE0
`define UDISC_IDX_PFLAGS 8'hE1
`define UDISC_IDX_PMASK 8'hE2
`define UDISC_IDX_ESUM 8'hE3
`define UDISC_IDX_EMASK 8'hE4
`define UDISC_IDX_GSTAT 8'hE5
`define UDISC_IDX_SYS 8'hE6
`define UDISC_IDX_EPSTAT 8'hE7
// Control register fields
`define UDISC_CR_WAKE_REQ 7
`define UDISC_CR_PULLUP 5
`define UDISC_CR_ENABLE 1
`define UDISC_CR_WMASK 8'hA2
// Protocol flag fields
`define UDISC_PF_RESET_END 4
`define UDISC_PF_SOF 3
`define UDISC_PF_WAKE 2
`define UDISC_PF_RESUME 1
`define UDISC_PF_SUSPEND 0
`define UDISC_PF_WMASK 8'h1F
`define UDISC_PM_WMASK 8'h0F
`define UDISC_PM_RESET 8'h02
// General status fields
`define UDISC_GS_WAKE_EN 0
`define UDISC_GS_SIGNALLING 1
// System register fields
`define UDISC_SYS_GIE 0
`define UDISC_SYS_PWR_REDUCE 1
// Vector addresses
`define UDISC_VEC_ENDPOINT 16'h003E
`define UDISC_VEC_PROTOCOL 16'h0040
// Timing: clock in MHz, durations in microseconds
`define UDISC_CLK_MHZ 20
`define UDISC_SUSPEND_US 3000
`define UDISC_WAKE_K_US 13000
`endif

//--- udisc_pkg.sv
// Types shared by the USB control and event logic
package udisc_pkg;
  typedef enum logic [2:0] {
    UDISC_WK_IDLE = 3'b001,
    UDISC_WK_DRIVE = 3'b010,
    UDISC_WK_DONE = 3'b100
  } udisc_wake_t;
endpackage

//--- udisc_ctrl_props.sv
// Port-level checks on the USB control and event block
`timescale 1ns/1ps
`include "udisc_consts.svh"

module udisc_ctrl_props #(
  parameter int WAKE_K_CYCLES = 260000,
  parameter int NUM_EP = 8
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_remote_wake_enable,
  input wire logic [NUM_EP-1:0] i_ep_ready,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_drive_k,
  input wire logic o_pullup_connect,
  input wire logic o_module_run,
  input wire logic o_osc_off,
  input wire logic o_wakeup,
  input wire logic o_irq_endpoint,
  input wire logic o_irq_protocol,
  input wire logic [15:0] o_irq_vector,
  input wire logic [NUM_EP-1:0] o_ep_nak
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  int kcnt;
  int next_kcnt;
  // Length of the current K burst, cleared between bursts
  always_comb next_kcnt = o_drive_k ? kcnt + 1 : 0;
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst) kcnt <= 0;
    else kcnt <= next_kcnt;
  sequence s_open;
    $rose(i_penable) && i_psel;
  endsequence
  sequence s_done;
    i_psel && i_penable && o_pready;
  endsequence
  sequence s_steady;
    (o_module_run && $stable(i_ep_ready))[*4];
  endsequence
  property p_pullup;
    logic d;
    (s_done ##0 (i_pwrite && i_paddr == 12'h380, d = i_pwdata[5])) |-> ##[1:2] o_pullup_connect == d;
  endproperty
  AST_ONE_WAIT: assert property (s_open |-> !o_pready ##1 o_pready)
    else $error("answer not after one wait state");
  AST_READY_PULSE: assert property (s_done |=> !o_pready)
    else $error("ready stood more than one cycle");
  AST_SLVERR: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  AST_PULLUP: assert property (p_pullup)
    else $error("pull-up does not follow control bit");
  AST_VEC_EP: assert property (o_irq_endpoint |-> o_irq_vector == `UDISC_VEC_ENDPOINT)
    else $error("endpoint vector wrong");
  AST_VEC_PR: assert property (o_irq_protocol && !o_irq_endpoint |-> o_irq_vector == `UDISC_VEC_PROTOCOL)
    else $error("protocol vector wrong");
  AST_FROZEN: assert property (!o_module_run[*3] |-> !o_irq_protocol && !o_irq_endpoint && !o_drive_k)
    else $error("activity while frozen");
  AST_K_LEN: assert property ($fell(o_drive_k) |-> kcnt >= WAKE_K_CYCLES - 1 && kcnt <= WAKE_K_CYCLES + 1)
    else $error("K burst length wrong");
  AST_K_GATE: assert property ($rose(o_drive_k) |-> i_remote_wake_enable)
    else $error("K without wake enable");
  AST_NAK: assert property (s_steady |-> o_ep_nak == ~i_ep_ready)
    else $error("nak not inverse of ready");
  AST_WAKE: assert property (o_wakeup |-> $past(o_osc_off, 1) || $past(o_osc_off, 2))
    else $error("wakeup outside suspend");
endmodule // udisc_ctrl_props

bind udisc_ctrl udisc_ctrl_props #(.WAKE_K_CYCLES(WAKE_K_CYCLES), .NUM_EP(NUM_EP)) u_props (
  .i_clock, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_remote_wake_enable, .i_ep_ready, .o_pready, .o_pslverr, .o_drive_k,
  .o_pullup_connect, .o_module_run, .o_osc_off, .o_wakeup, .o_irq_endpoint,
  .o_irq_protocol, .o_irq_vector, .o_ep_nak);

//--- udisc_host_model.sv
// Behavioural full-speed host driving the bus event lines
`timescale 1ns/1ps

module udisc_host_model
(
  input wire logic i_clock,
  output logic o_bus_idle = 1'b0,
  output logic o_bus_reset = 1'b0,
  output logic o_sof_pid = 1'b0,
  output logic o_bus_resume = 1'b0
);
  // Bus reset held n cycles; its end is the falling edge
  task automatic pulse_reset(input int n);
    o_bus_reset <= 1'b1;
    repeat (n) @(posedge i_clock);
    o_bus_reset <= 1'b0;
  endtask
  // One frame start token
  task automatic sof();
    o_sof_pid <= 1'b1;
    @(posedge i_clock);
    o_sof_pid <= 1'b0;
  endtask
  // Traffic stops and stays stopped: the suspend request
  task automatic go_idle();
    o_bus_idle <= 1'b1;
  endtask
  // Resume ends the idle period
  task automatic resume(input int n);
    o_bus_idle <= 1'b0;
    o_bus_resume <= 1'b1;
    repeat (n) @(posedge i_clock);
    o_bus_resume <= 1'b0;
  endtask
endmodule // udisc_host_model

//--- testbench.sv
// Self-checking bench for the USB control and event block
`timescale 1ns/1ps
`include "udisc_consts.svh"
`define CHECK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end

module testbench;
  localparam int SUSP = 20;
  localparam int WAKE = 30;
  localparam logic [7:0] CR = `UDISC_IDX_CTRL;
  localparam logic [7:0] PF = `UDISC_IDX_PFLAGS;
  localparam logic [7:0] PM = `UDISC_IDX_PMASK;
  localparam logic [7:0] GS = `UDISC_IDX_GSTAT;
  localparam logic [7:0] SY = `UDISC_IDX_SYS;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, err, i_bus_idle, i_bus_reset, i_sof_pid, i_bus_resume;
  logic i_remote_wake_enable = 1'b1;
  logic [7:0] i_ep_cause = 8'h00, i_ep_ready = 8'hFF, i_ep_bank_release = 8'h00;
  logic [7:0] o_ep_nak, o_ep_bank;
  logic o_drive_k, o_pullup_connect, o_module_run, o_osc_off, o_wakeup;
  logic o_irq_endpoint, o_irq_protocol;
  logic [15:0] o_irq_vector;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  int wake_pulses = 0;

  always #25 i_clock = ~i_clock;
  // Wake-up pulses last one cycle, so a counter catches them
  always @(posedge i_clock) if (o_wakeup === 1'b1) wake_pulses <= wake_pulses + 1;

  udisc_ctrl #(.SUSPEND_CYCLES(SUSP), .WAKE_K_CYCLES(WAKE)) i_udisc_ctrl (
    .i_clock, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_bus_idle, .i_bus_reset, .i_sof_pid, .i_bus_resume,
    .i_remote_wake_enable, .i_ep_cause, .i_ep_ready, .i_ep_bank_release, .o_drive_k,
    .o_pullup_connect, .o_module_run, .o_osc_off, .o_wakeup, .o_irq_endpoint,
    .o_irq_protocol, .o_irq_vector, .o_ep_nak, .o_ep_bank);
  udisc_host_model i_udisc_host_model (.i_clock, .o_bus_idle(i_bus_idle),
    .o_bus_reset(i_bus_reset), .o_sof_pid(i_sof_pid), .o_bus_resume(i_bus_resume));

  // One APB transfer; waits for ready, never a fixed count
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int w;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= {2'h0, idx, 2'h0};
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    w = 0;
    @(posedge i_clock);
    while (o_pready !== 1'b1 && w < 20)
    begin
      @(posedge i_clock);
      w++;
    end
    if (w == 20) fail_count++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    `CHECK(rd, e)
  endtask
  task t_regs;
    rdc(CR, 32'h0);
    rdc(PM, 32'h2);
    apb(1'b0, 8'hF0, 32'h0);
    `CHECK(err, 1'b1)
    apb(1'b1, CR, 32'h0);
    apb(1'b1, CR, 32'h7F);
    rdc(CR, 32'h22);
    `CHECK({o_pullup_connect, o_module_run}, 2'b11)
    apb(1'b1, PM, 32'hFF);
    rdc(PM, 32'h0F);
    apb(1'b1, SY, 32'h1);
  endtask
  task t_flags;
    apb(1'b1, PM, 32'h0);
    i_udisc_host_model.pulse_reset(4);
    repeat (8) @(posedge i_clock);
    rdc(PF, 32'h10);
    `CHECK({o_irq_protocol, o_irq_vector}, {1'b1, `UDISC_VEC_PROTOCOL})
    apb(1'b1, PF, 32'h0);
    rdc(PF, 32'h0);
    apb(1'b1, PF, 32'hFF);
    rdc(PF, 32'h1F);
    apb(1'b1, PF, 32'hF);
    @(posedge i_clock);
    `CHECK(o_irq_protocol, 1'b0)
    apb(1'b1, PF, 32'h0);
    apb(1'b1, PM, 32'h8);
    i_udisc_host_model.sof();
    repeat (6) @(posedge i_clock);
    rdc(PF, 32'h8);
    `CHECK(o_irq_protocol, 1'b1)
    apb(1'b1, SY, 32'h0);
    repeat (3) @(posedge i_clock);
    `CHECK(o_irq_protocol, 1'b0)
    apb(1'b1, SY, 32'h1);
    apb(1'b1, PF, 32'h0);
  endtask
  task t_susp;
    apb(1'b1, PM, 32'h3);
    i_udisc_host_model.go_idle();
    repeat (SUSP + 10) @(posedge i_clock);
    rdc(PF, 32'h1);
    `CHECK({o_osc_off, o_irq_protocol}, 2'b11)
    apb(1'b1, PF, 32'h0);
    i_udisc_host_model.resume(5);
    repeat (8) @(posedge i_clock);
    apb(1'b0, PF, 32'h0);
    `CHECK(rd[1], 1'b1)
    `CHECK(wake_pulses, 1)
    `CHECK(o_osc_off, 1'b1)
    apb(1'b1, PF, 32'h0);
    @(posedge i_clock);
    `CHECK(o_osc_off, 1'b0)
  endtask
  task t_wake;
    i_remote_wake_enable <= 1'b0;
    i_udisc_host_model.go_idle();
    repeat (SUSP + 10) @(posedge i_clock);
    apb(1'b1, CR, 32'hA2);
    repeat (10) @(posedge i_clock);
    `CHECK(o_drive_k, 1'b0)
    rdc(GS, 32'h0);
    i_remote_wake_enable <= 1'b1;
    for (n = 0; n < 20 && o_drive_k !== 1'b1; n++) @(posedge i_clock);
    `CHECK(o_drive_k, 1'b1)
    rdc(GS, 32'h3);
    for (n = 0; n < 100 && o_drive_k !== 1'b0; n++) @(posedge i_clock);
    rdc(GS, 32'h1);
    apb(1'b0, PF, 32'h0);
    `CHECK(rd[2], 1'b1)
    apb(1'b1, CR, 32'h22);
    i_udisc_host_model.resume(5);
    repeat (8) @(posedge i_clock);
    `CHECK(wake_pulses, 2)
    apb(1'b1, PF, 32'h0);
  endtask
  task t_power;
    apb(1'b1, SY, 32'h3);
    i_udisc_host_model.sof();
    repeat (6) @(posedge i_clock);
    `CHECK(o_module_run, 1'b0)
    rdc(PF, 32'h0);
    apb(1'b1, SY, 32'h1);
    apb(1'b1, CR, 32'h20);
    repeat (3) @(posedge i_clock);
    `CHECK(o_module_run, 1'b0)
    apb(1'b1, CR, 32'h22);
  endtask
  task t_ep;
    i_ep_ready <= 8'h0F;
    i_ep_cause <= 8'h04;
    apb(1'b1, `UDISC_IDX_EMASK, 32'h4);
    repeat (4) @(posedge i_clock);
    `CHECK(o_ep_nak, 8'hF0)
    rdc(`UDISC_IDX_ESUM, 32'h4);
    `CHECK({o_irq_endpoint, o_irq_vector}, {1'b1, `UDISC_VEC_ENDPOINT})
    apb(1'b1, `UDISC_IDX_EMASK, 32'h0);
    repeat (3) @(posedge i_clock);
    `CHECK(o_irq_endpoint, 1'b0)
    i_ep_bank_release <= 8'h03;
    @(posedge i_clock);
    i_ep_bank_release <= 8'h00;
    repeat (4) @(posedge i_clock);
    `CHECK(o_ep_bank, 8'h02)
    rdc(`UDISC_IDX_EPSTAT, 32'h2F0);
  endtask
  task give_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence after a five-cycle reset
  initial
  begin
    repeat (5) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_regs;
    t_flags;
    t_susp;
    t_wake;
    t_power;
    t_ep;
    give_verdict;
  end
  // Watchdog, far beyond the expected run of some 350 cycles
  initial
  begin
    #(50 * 5000);
    fail_count++;
    give_verdict;
  end
endmodule // testbench
